//--- sfad_datapath.sv
module sfad_datapath (
  input  wire logic                    I_CORE_CLK,
  input  wire logic                    I_RESET,
  input  wire logic [3:0]              I_AXI_AWADDR,
  input  wire logic                    I_AXI_AWVALID,
  output logic                         O_AXI_AWREADY,
  input  wire logic [31:0]             I_AXI_WDATA,
  input  wire logic [3:0]              I_AXI_WSTRB,
  input  wire logic                    I_AXI_WVALID,
  output logic                         O_AXI_WREADY,
  output logic [1:0]                   O_AXI_BRESP,
  output logic                         O_AXI_BVALID,
  input  wire logic                    I_AXI_BREADY,
  input  wire logic [3:0]              I_AXI_ARADDR,
  input  wire logic                    I_AXI_ARVALID,
  output logic                         O_AXI_ARREADY,
  output logic [31:0]                  O_AXI_RDATA,
  output logic [1:0]                   O_AXI_RRESP,
  output logic                         O_AXI_RVALID,
  input  wire logic                    I_AXI_RREADY,
  output sfad_pkg::sfad_file_req_t     O_FILE_REQ,
  input  wire logic [7:0]              I_FILE_RDATA,
  output logic [7:0]                   O_ACCUM,
  output logic [4:0]                   O_FLAGS,
  output logic                         O_BUSY
);
  sfad_pkg::sfad_state_t st;
  sfad_pkg::sfad_state_t next_st;

  function automatic logic is_mapped(input logic [3:0] a);
    return a == sfad_pkg::REG_INSTR || a == sfad_pkg::REG_ACCUM ||
           a == sfad_pkg::REG_STATUS || a == sfad_pkg::REG_BANK;
  endfunction : is_mapped

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  // minuend minus subtrahend by adding the complement; carry out means no borrow
  function automatic sfad_pkg::sfad_alu_t subtract(input logic [7:0] m, input logic [7:0] s);
    sfad_pkg::sfad_alu_t r;
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, m} + {1'b0, ~s} + 9'h001;
    low  = {1'b0, m[3:0]} + {1'b0, ~s[3:0]} + 5'h01;
    r.result               = full[7:0];
    r.flags                = 5'h00;
    r.flags[sfad_pkg::FLG_C]  = full[8];
    r.flags[sfad_pkg::FLG_DC] = low[4];
    r.flags[sfad_pkg::FLG_Z]  = full[7:0] == 8'h00;
    r.flags[sfad_pkg::FLG_OV] = (m[7] != s[7]) && (full[7] != m[7]);
    r.flags[sfad_pkg::FLG_N]  = full[7];
    return r;
  endfunction : subtract

  function automatic logic [31:0] read_reg(input logic [3:0] a, input sfad_pkg::sfad_state_t s);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      sfad_pkg::REG_INSTR:  d[15:0] = s.instr;
      sfad_pkg::REG_ACCUM:  d[7:0]  = s.accum;
      sfad_pkg::REG_STATUS: begin
        d[4:0]                    = s.flags;
        d[sfad_pkg::STAT_BUSY]    = s.ph != sfad_pkg::PH_IDLE;
        d[sfad_pkg::STAT_ILLEGAL] = s.illegal;
      end
      sfad_pkg::REG_BANK:   d[3:0]  = s.bank;
      default:              d       = 32'h0000_0000;
    endcase
    return d;
  endfunction : read_reg

  logic [31:0] wr_word;
  logic        wr_fire;

  assign O_AXI_AWREADY = !st.aw_full;
  assign O_AXI_WREADY  = !st.w_full;
  assign O_AXI_ARREADY = !st.r_valid;
  assign O_AXI_BVALID  = st.b_valid;
  assign O_AXI_BRESP   = st.b_resp;
  assign O_AXI_RVALID  = st.r_valid;
  assign O_AXI_RDATA   = st.r_data;
  assign O_AXI_RRESP   = st.r_resp;
  assign O_FILE_REQ    = st.file_req;
  assign O_ACCUM       = st.accum;
  assign O_FLAGS       = st.flags;
  assign O_BUSY        = st.ph != sfad_pkg::PH_IDLE;

  always_comb begin
    next_st = st;
    wr_fire = st.aw_full && st.w_full && !st.b_valid;
    wr_word = merge(read_reg(st.aw_addr, st), st.w_data, st.w_strb);
    // bus slave: address and data taken in either order, applied once both are held
    if (I_AXI_AWVALID && !st.aw_full) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = I_AXI_AWADDR;
    end
    if (I_AXI_WVALID && !st.w_full) begin
      next_st.w_full = 1'b1;
      next_st.w_data = I_AXI_WDATA;
      next_st.w_strb = I_AXI_WSTRB;
    end
    if (st.b_valid && I_AXI_BREADY) begin
      next_st.b_valid = 1'b0;
    end
    if (wr_fire) begin
      next_st.aw_full = 1'b0;
      next_st.w_full  = 1'b0;
      next_st.b_valid = 1'b1;
      next_st.b_resp  = is_mapped(st.aw_addr) ? sfad_pkg::RESP_OKAY : sfad_pkg::RESP_SLVERR;
    end
    if (st.r_valid && I_AXI_RREADY) begin
      next_st.r_valid = 1'b0;
    end
    if (I_AXI_ARVALID && !st.r_valid) begin
      next_st.r_valid = 1'b1;
      next_st.r_data  = read_reg(I_AXI_ARADDR, st);
      next_st.r_resp  = is_mapped(I_AXI_ARADDR) ? sfad_pkg::RESP_OKAY : sfad_pkg::RESP_SLVERR;
    end
    // execution phases
    unique case (st.ph)
      sfad_pkg::PH_IDLE: begin
        if (wr_fire && st.aw_addr == sfad_pkg::REG_INSTR) begin
          next_st.instr   = wr_word[15:0];
          next_st.illegal = 1'b0;
          next_st.ph      = sfad_pkg::PH_Q1;
        end
        if (wr_fire && st.aw_addr == sfad_pkg::REG_ACCUM) begin
          next_st.accum = wr_word[7:0];
        end
        if (wr_fire && st.aw_addr == sfad_pkg::REG_BANK) begin
          next_st.bank = wr_word[3:0];
        end
      end
      sfad_pkg::PH_Q1: begin
        if (st.instr[15:8] == sfad_pkg::OPC_LIT) begin
          next_st.is_file = 1'b0;
          next_st.ph      = sfad_pkg::PH_Q2;
        end else if (st.instr[15:10] == sfad_pkg::OPC_FILE) begin
          next_st.is_file       = 1'b1;
          next_st.file_req.rd   = 1'b1;
          next_st.file_req.addr = {st.instr[sfad_pkg::ACC_BIT] ? st.bank
                                   : sfad_pkg::ACCESS_BANK, st.instr[7:0]};
          next_st.ph            = sfad_pkg::PH_Q2;
        end else begin
          next_st.illegal = 1'b1;
          next_st.ph      = sfad_pkg::PH_IDLE;
        end
      end
      sfad_pkg::PH_Q2: begin
        next_st.operand     = st.is_file ? I_FILE_RDATA : st.instr[7:0];
        next_st.file_req.rd = 1'b0;
        next_st.ph          = sfad_pkg::PH_Q3;
      end
      sfad_pkg::PH_Q3: begin
        next_st.alu = subtract(st.operand, st.accum);
        if (st.is_file && st.instr[sfad_pkg::DEST_BIT]) begin
          next_st.file_req.we    = 1'b1;
          next_st.file_req.wdata = next_st.alu.result;
        end
        next_st.ph = sfad_pkg::PH_Q4;
      end
      sfad_pkg::PH_Q4: begin
        next_st.flags = st.alu.flags;
        if (!st.is_file || !st.instr[sfad_pkg::DEST_BIT]) begin
          next_st.accum = st.alu.result;
        end
        next_st.file_req.we = 1'b0;
        next_st.ph          = sfad_pkg::PH_IDLE;
      end
      default: next_st.ph = sfad_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      st          <= '0;
      st.ph       <= sfad_pkg::PH_IDLE;
      st.instr    <= sfad_pkg::INSTR_RST;
      st.accum    <= sfad_pkg::ACCUM_RST;
      st.bank     <= sfad_pkg::BANK_RST;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);

  logic lit_q1;
  logic file_q4;
  assign lit_q1  = st.ph == sfad_pkg::PH_Q1 && st.instr[15:8] == sfad_pkg::OPC_LIT;
  assign file_q4 = st.ph == sfad_pkg::PH_Q4 && st.is_file;

  sequence s_phases;
    st.ph == sfad_pkg::PH_Q2 ##1 st.ph == sfad_pkg::PH_Q3 ##1
    st.ph == sfad_pkg::PH_Q4 ##1 st.ph == sfad_pkg::PH_IDLE;
  endsequence
  sequence s_q4_done;
    st.ph == sfad_pkg::PH_Q4 ##1 st.ph == sfad_pkg::PH_IDLE;
  endsequence

  property p_lit_result;
    (st.ph == sfad_pkg::PH_Q4 && !st.is_file)
      |=> st.accum == 8'($past(st.operand) - $past(st.accum));
  endproperty
  a_lit_result: assert property (p_lit_result) else $error("literal result wrong");
  property p_lit_decode;
    lit_q1 |=> !st.is_file && !st.illegal ##2 st.operand == $past(st.instr[7:0], 2);
  endproperty
  a_lit_decode: assert property (p_lit_decode) else $error("literal decode wrong");
  property p_one_cycle;
    (st.ph == sfad_pkg::PH_Q1 && !(next_st.illegal)) |=> s_phases;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("phase order wrong");
  property p_positive;
    (st.ph == sfad_pkg::PH_Q4 && st.operand > st.accum && !st.alu.result[7])
      |=> st.flags[sfad_pkg::FLG_C] && !st.flags[sfad_pkg::FLG_Z] && !st.flags[sfad_pkg::FLG_N];
  endproperty
  a_positive: assert property (p_positive) else $error("positive flags wrong");
  property p_equal;
    (st.ph == sfad_pkg::PH_Q4 && st.operand == st.accum) |=> st.flags[sfad_pkg::FLG_Z]
      && st.flags[sfad_pkg::FLG_C] && !st.flags[sfad_pkg::FLG_N] && $past(st.alu.result) == 8'h00;
  endproperty
  a_equal: assert property (p_equal) else $error("zero case wrong");
  property p_borrow;
    (st.ph == sfad_pkg::PH_Q4 && st.operand < st.accum) |=> !st.flags[sfad_pkg::FLG_C];
  endproperty
  a_borrow: assert property (p_borrow) else $error("borrow not shown");
  property p_all_ones;
    (st.ph == sfad_pkg::PH_Q3 && 8'(st.operand + 8'h01) == st.accum)
      |=> st.alu.result == 8'hff;
  endproperty
  a_all_ones: assert property (p_all_ones) else $error("wraparound wrong");
  property p_dest;
    file_q4 |-> (st.file_req.we == st.instr[sfad_pkg::DEST_BIT])
      ##1 (st.accum == ($past(st.instr[sfad_pkg::DEST_BIT]) ? $past(st.accum) : $past(st.alu.result)));
  endproperty
  a_dest: assert property (p_dest) else $error("destination wrong");
  property p_bank;
    (st.ph == sfad_pkg::PH_Q2 && st.is_file) |-> st.file_req.rd && st.file_req.addr ==
      {st.instr[sfad_pkg::ACC_BIT] ? st.bank : sfad_pkg::ACCESS_BANK, st.instr[7:0]};
  endproperty
  a_bank: assert property (p_bank) else $error("file address wrong");
  property p_file_result;
    (file_q4 && st.instr[sfad_pkg::DEST_BIT])
      |-> st.file_req.wdata == 8'(st.operand - st.accum) and s_q4_done;
  endproperty
  a_file_result: assert property (p_file_result) else $error("file result wrong");
endmodule : sfad_datapath

//--- sfad_pkg.sv
package sfad_pkg;
  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned DATA_W    = 32;
  // register byte offsets
  localparam logic [3:0]  REG_INSTR  = 4'h0;
  localparam logic [3:0]  REG_ACCUM  = 4'h4;
  localparam logic [3:0]  REG_STATUS = 4'h8;
  localparam logic [3:0]  REG_BANK   = 4'hc;
  // opcode patterns and operand fields
  localparam logic [7:0]  OPC_LIT    = 8'h08;
  localparam logic [5:0]  OPC_FILE   = 6'h17;
  localparam int unsigned DEST_BIT   = 9;
  localparam int unsigned ACC_BIT    = 8;
  localparam logic [3:0]  ACCESS_BANK = 4'h0;
  // flag positions inside the five-bit flag field, then busy and illegal bit positions in the status word
  localparam int unsigned FLG_C  = 0;
  localparam int unsigned FLG_DC = 1;
  localparam int unsigned FLG_Z  = 2;
  localparam int unsigned FLG_OV = 3;
  localparam int unsigned FLG_N  = 4;
  localparam int unsigned STAT_BUSY    = 8;
  localparam int unsigned STAT_ILLEGAL = 9;
  // reset values and bus answers
  localparam logic [7:0]  ACCUM_RST = 8'h00;
  localparam logic [3:0]  BANK_RST  = 4'h0;
  localparam logic [15:0] INSTR_RST = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_Q1   = 3'b001,
    PH_Q2   = 3'b010,
    PH_Q3   = 3'b011,
    PH_Q4   = 3'b100
  } sfad_phase_t;

  typedef struct packed {
    logic [11:0] addr;
    logic        rd;
    logic        we;
    logic [7:0]  wdata;
  } sfad_file_req_t;

  typedef struct packed {
    logic [7:0] result;
    logic [4:0] flags;
  } sfad_alu_t;

  typedef struct packed {
    sfad_phase_t    ph;
    logic [15:0]    instr;
    logic           is_file;
    logic           illegal;
    logic [7:0]     operand;
    sfad_alu_t      alu;
    logic [7:0]     accum;
    logic [4:0]     flags;
    logic [3:0]     bank;
    sfad_file_req_t file_req;
    logic           aw_full;
    logic [3:0]     aw_addr;
    logic           w_full;
    logic [31:0]    w_data;
    logic [3:0]     w_strb;
    logic           b_valid;
    logic [1:0]     b_resp;
    logic           r_valid;
    logic [31:0]    r_data;
    logic [1:0]     r_resp;
  } sfad_state_t;
endpackage : sfad_pkg

//--- sfad_rf_model.sv
module sfad_rf_model (
  input  wire logic                     i_clk,
  input  wire sfad_pkg::sfad_file_req_t i_req,
  output logic [7:0]                    o_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:4095];
  logic [7:0] last;
  initial last = 8'h5a;
  always @(posedge i_clk) begin
    if (i_req.we) mem[i_req.addr] <= i_req.wdata;
    if (i_req.rd) last <= mem[i_req.addr];
  end
  // released read bus shows the inverse of the last value, not a stale copy
  assign o_rdata = i_req.rd ? mem[i_req.addr] : ~last;
endmodule : sfad_rf_model

//--- tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1;
  logic [3:0] awaddr = '0, araddr = '0, wstrb = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0;
  logic awready, wready, bvalid, arready, rvalid, busy;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] frd, accum;
  logic [4:0] flags;
  sfad_pkg::sfad_file_req_t freq;
  int failures = 0, samples_checked = 0, busy_cnt = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (busy) busy_cnt <= busy_cnt + 1;
  sfad_datapath dut (.I_CORE_CLK(clk), .I_RESET(rst), .I_AXI_AWADDR(awaddr),
    .I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(wstrb),
    .I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid),
    .I_AXI_BREADY(bready), .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid),
    .O_AXI_ARREADY(arready), .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid),
    .I_AXI_RREADY(rready), .O_FILE_REQ(freq), .I_FILE_RDATA(frd), .O_ACCUM(accum),
    .O_FLAGS(flags), .O_BUSY(busy));
  sfad_rf_model u_rf (.i_clk(clk), .i_req(freq), .o_rdata(frd));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
                           input logic [1:0] er = sfad_pkg::RESP_OKAY);
    int n;
    @(posedge clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hf; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    check("write answered", 1, {31'h0, n < 100});
    check("write response", {30'h0, er}, {30'h0, bresp});
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d,
                          input logic [1:0] er = sfad_pkg::RESP_OKAY);
    int n;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    d = 'x;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        break;
      end
    end
    rready <= 1'b0;
    check("read answered", 1, {31'h0, n < 100});
    check("read response", {30'h0, er}, {30'h0, rresp});
  endtask : axi_read

  function automatic logic [4:0] exp_flags(input logic [7:0] m, input logic [7:0] s);
    logic [8:0] d;
    logic [4:0] f;
    d = {1'b0, m} - {1'b0, s};
    f = '0;
    f[sfad_pkg::FLG_C]  = ~d[8];
    f[sfad_pkg::FLG_DC] = (m[3:0] >= s[3:0]);
    f[sfad_pkg::FLG_Z]  = (d[7:0] == 8'h00);
    f[sfad_pkg::FLG_N]  = d[7];
    f[sfad_pkg::FLG_OV] = (m[7] ^ s[7]) & (m[7] ^ d[7]);
    return f;
  endfunction : exp_flags

  // starts an instruction, waits for the idle phase and checks the cycle count
  task automatic run_instr(input logic [15:0] ins, input int cycles);
    int n;
    busy_cnt = 0;
    axi_write(sfad_pkg::REG_INSTR, {16'h0, ins});
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (busy_cnt > 0 && busy === 1'b0) break;
    end
    check("busy cycles", cycles, busy_cnt);
  endtask : run_instr

  task automatic t_reset_regs();
    logic [31:0] d;
    axi_read(sfad_pkg::REG_ACCUM, d);
    check("accum reset", {24'h0, sfad_pkg::ACCUM_RST}, d);
    axi_read(sfad_pkg::REG_BANK, d);
    check("bank reset", {28'h0, sfad_pkg::BANK_RST}, d);
    axi_write(sfad_pkg::REG_STATUS, 32'hffffffff);
    axi_read(sfad_pkg::REG_STATUS, d);
    check("status read only", 32'h0, {22'h0, d[9:0]});
  endtask : t_reset_regs

  task automatic t_literal(input logic [7:0] w, input logic [7:0] k);
    logic [31:0] d;
    axi_write(sfad_pkg::REG_ACCUM, {24'h0, w});
    run_instr({sfad_pkg::OPC_LIT, k}, 4);
    check("accum port", {24'h0, 8'(k - w)}, {24'h0, accum});
    check("flags port", exp_flags(k, w), flags);
    axi_read(sfad_pkg::REG_ACCUM, d);
    check("accum read", {24'h0, k - w}, d);
    axi_read(sfad_pkg::REG_STATUS, d);
    check("status flags", {27'h0, exp_flags(k, w)}, {27'h0, d[4:0]});
  endtask : t_literal

  task automatic t_file(input logic [7:0] f, input logic [7:0] w, input logic [7:0] fv,
                        input logic dst, input logic acc, input logic [3:0] bank);
    logic [11:0] hit, miss;
    hit  = acc ? {bank, f} : {sfad_pkg::ACCESS_BANK, f};
    miss = acc ? {sfad_pkg::ACCESS_BANK, f} : {bank, f};
    u_rf.mem[hit]  = fv;
    u_rf.mem[miss] = 8'h77;
    axi_write(sfad_pkg::REG_BANK, {28'h0, bank});
    axi_write(sfad_pkg::REG_ACCUM, {24'h0, w});
    run_instr({sfad_pkg::OPC_FILE, dst, acc, f}, 4);
    check("flags file", exp_flags(fv, w), flags);
    check("accum file", {24'h0, dst ? w : 8'(fv - w)}, {24'h0, accum});
    check("reg file", {24'h0, dst ? 8'(fv - w) : fv}, {24'h0, u_rf.mem[hit]});
    check("other bank", 8'h77, u_rf.mem[miss]);
  endtask : t_file

  task automatic t_illegal();
    logic [31:0] d;
    axi_write(sfad_pkg::REG_ACCUM, 32'h0000005c);
    run_instr(16'h0900, 1);
    check("accum kept", 8'h5c, accum);
    axi_read(sfad_pkg::REG_STATUS, d);
    check("illegal bit", 1, {31'h0, d[sfad_pkg::STAT_ILLEGAL]});
    // unmapped offset answers with an error and reads as zero
    axi_write(4'h2, 32'h0000_00a5, sfad_pkg::RESP_SLVERR);
    axi_read(4'h2, d, sfad_pkg::RESP_SLVERR);
    check("unmapped data", 32'h0, d);
  endtask : t_illegal

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset_regs();
    t_literal(8'h01, 8'h02);
    t_literal(8'h02, 8'h02);
    t_literal(8'h03, 8'h02);
    t_literal(8'h01, 8'h80);
    t_literal(8'h01, 8'h10);
    t_file(8'h20, 8'h02, 8'h03, 1'b1, 1'b0, 4'h5);
    t_file(8'h21, 8'h02, 8'h01, 1'b0, 1'b1, 4'h5);
    t_file(8'h22, 8'h02, 8'h02, 1'b1, 1'b1, 4'h3);
    t_illegal();
    stop_test();
  end

  initial begin
    #(5000 * 5);
    failures++;
    stop_test();
  end
endmodule : tb
